/* design/power_seq_regs.vh */
// Constants for the radio power sequencer: timing, states, targets.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef POWER_SEQ_REGS_VH
`define POWER_SEQ_REGS_VH
// Settling delay after supply good, in microseconds
`define SETTLE_US        32'd1000
`define CLK_MHZ          32'd10
// Bus clock half period in system clocks
`define SCK_HALF         8'h04
// Reset vector addresses
`define VEC_LO_ADDR      16'hFFFE
`define VEC_HI_ADDR      16'hFFFF
// Last bit index of a frame, reference edge count, baseband config byte
`define LAST_BIT         4'h7
`define REF_SEEN_CNT     8'hFF
`define BBC_CFG_BYTE     8'hA5
// Target select indices
`define TGT_NUM          3'h4
`define TGT_BBC          3'h0
// Sequencer states
`define S_RESET          5'h00
`define S_SETTLE         5'h01
`define S_VEC_LO         5'h02
`define S_VEC_HI         5'h03
`define S_MAP            5'h04
`define S_CFG_XCVR       5'h05
`define S_REL_CONV       5'h06
`define S_CFG_BBC        5'h07
`define S_DSP_GO         5'h08
`define S_DIAG_RAM       5'h09
`define S_DIAG_FLASH     5'h0A
`define S_DIAG_DSP       5'h0B
`define S_ERROR          5'h0C
`define S_RUN            5'h0D
`define S_SAVE           5'h0E
`define S_OFF            5'h0F
`define S_WAIT_XFER      5'h10
// Error codes shown on the display
`define ERR_NONE         8'h00
`define ERR_RAM          8'h01
`define ERR_FLASH        8'h02
`define ERR_DSP_STATUS   8'h03
`define ERR_DSP_TEST     8'h04
`endif

/* design/sync2.v */
// Two flip-flop synchroniser for asynchronous level inputs.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         resetn,
  input  wire         ce,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_q;

  // First stage feeds only the second stage
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* design/cfg_bus_master.v */
// Serial configuration bus master, mode 0, MSB first, 8-bit frames.
// Assumes one request at a time; start only while busy is low.
`include "power_seq_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module cfg_bus_master #(
  parameter NT = 4,
  parameter TW = 3
) (
  input  wire          clk,
  input  wire          resetn,
  input  wire          ce,
  input  wire          start,
  input  wire [TW-1:0] target,
  input  wire [7:0]    tx_byte,
  input  wire          miso_s,
  output reg           busy,
  output reg  [7:0]    rx_byte,
  output reg           sck,
  output reg           mosi,
  output reg  [NT-1:0] sel_n
);
  reg [7:0] cnt_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  wire      tick = (cnt_q == `SCK_HALF - 8'h01);

  // Shift engine: data set on falling, sampled on rising clock edge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy    <= 1'b0;
      rx_byte <= 8'h00;
      sck     <= 1'b0;
      mosi    <= 1'b0;
      sel_n   <= {NT{1'b1}};
      cnt_q   <= 8'h00;
      bit_q   <= 4'h0;
      sh_q    <= 8'h00;
    end else if (ce) begin
      if (!busy) begin
        // R17 all deselected idle
        sel_n <= {NT{1'b1}};
        sck   <= 1'b0;
        if (start) begin
          busy  <= 1'b1;
          // R2 select target low
          sel_n <= ~({{(NT-1){1'b0}}, 1'b1} << target);
          mosi  <= tx_byte[7];
          sh_q  <= tx_byte;
          bit_q <= 4'h0;
          cnt_q <= 8'h00;
        end
      end else begin
        cnt_q <= tick ? 8'h00 : cnt_q + 8'h01;
        if (tick) begin
          // R1 master drives clock
          sck <= ~sck;
          if (!sck) begin
            // R3 sample return data
            sh_q <= {sh_q[6:0], miso_s};
          end else if (bit_q == `LAST_BIT) begin
            busy    <= 1'b0;
            sel_n   <= {NT{1'b1}};
            rx_byte <= sh_q;
          end else begin
            bit_q <= bit_q + 4'h1;
            mosi  <= sh_q[7];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* design/radio_power_sequencer.v */
// Radio power sequencer: reset release, boot order, diagnostics and
// orderly shutdown. Assumes asynchronous pins for detect, sense and
// handshakes; the flash/RAM/DSP checks report through status pins.
`include "power_seq_regs.vh"
`timescale 1ns/10ps
`default_nettype none
// Contract
// R1 - Controller solely masters configuration bus
// R2 - Select low addresses one target
// R3 - Only baseband converter returns data
// R4 - Main reference clock is rate basis; the code times everything on clk and only flags main_ref_seen
// R5 - Slow clock drives reset housekeeping; the code only outputs slow_tick and counts settling in clk cycles
// R6 - Reset released after supply good, settling
// R7 - Fetch reset vector FFFE then FFFF
// R8 - Configure transceivers before converter release
// R9 - Release converters then configure baseband
// R10 - Signal processor waits for configuration done
// R11 - Verify RAM, flash, processor self tests
// R12 - Failure shows error; else run idle
// R13 - Poll supply loss, start shutdown
// R14 - Hold supply enable during shutdown
// R15 - Save status before releasing enable
// R16 - Low voltage asserts system reset
// R17 - Selects high between transfers
module radio_power_sequencer #(
  parameter SETTLE_CYC = `SETTLE_US * `CLK_MHZ,
  parameter NT         = 4,
  parameter NX         = 3
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        ce,
  input  wire        main_ref_clock_in,
  input  wire        slow_ref_clock_in,
  input  wire        low_voltage_detect,
  input  wire        supply_loss_sense,
  input  wire        ram_ok,
  input  wire        flash_ok,
  input  wire        dsp_status_ok,
  input  wire        dsp_test_ok,
  input  wire        dsp_ready,
  input  wire        save_done,
  input  wire [7:0]  rom_data,
  input  wire        miso,
  output reg         sys_reset_n,
  output reg  [15:0] rom_addr,
  output reg  [15:0] start_addr,
  output reg         map_enable,
  output reg         converter_reset_n,
  output reg         bbc_config_done,
  output reg         dsp_query,
  output reg         save_req,
  output reg         supply_hold_enable,
  output reg  [7:0]  error_code,
  output reg         run_idle,
  output reg         main_ref_seen,
  output reg         slow_tick,
  output reg         sck,
  output reg         mosi,
  output reg  [NT-1:0] sel_n
);
  // Synchronised pins
  wire [10:0] raw = {main_ref_clock_in, slow_ref_clock_in,
                     low_voltage_detect, supply_loss_sense, ram_ok,
                     flash_ok, dsp_status_ok, dsp_test_ok, dsp_ready,
                     save_done, miso};
  wire [10:0] s;
  sync2 #(.W(11)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .d      (raw),
    .q      (s)
  );
  wire mref_s = s[10];
  wire sref_s = s[9];
  wire lvd_s  = s[8];
  wire loss_s = s[7];
  wire ram_s  = s[6];
  wire fl_s   = s[5];
  wire dst_s  = s[4];
  wire dte_s  = s[3];
  wire drdy_s = s[2];
  wire save_s = s[1];
  wire miso_s = s[0];

  // Rom data comes from logic on this clock and is read directly
  reg  [4:0]  st_q;
  reg  [4:0]  ret_q;
  reg  [31:0] set_q;
  reg  [2:0]  idx_q;
  reg  [7:0]  mref_cnt_q;
  reg         sref_q;
  reg         mref_q;
  reg         start_q;
  reg  [2:0]  tgt_q;
  reg  [7:0]  txb_q;
  wire        busy;
  wire [7:0]  rx_byte;
  wire        m_sck;
  wire        m_mosi;
  wire [NT-1:0] m_sel_n;
  reg         busy_d1_q;

  cfg_bus_master #(.NT(NT), .TW(3)) u_bus (
    .clk     (clk),
    .resetn  (resetn),
    .ce      (ce),
    .start   (start_q),
    .target  (tgt_q),
    .tx_byte (txb_q),
    .miso_s  (miso_s),
    .busy    (busy),
    .rx_byte (rx_byte),
    .sck     (m_sck),
    .mosi    (m_mosi),
    .sel_n   (m_sel_n)
  );

  // Bus pins registered at the top
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck   <= 1'b0;
      mosi  <= 1'b0;
      sel_n <= {NT{1'b1}};
    end else if (ce) begin
      // R1 sole master outputs
      sck   <= m_sck;
      mosi  <= m_mosi;
      sel_n <= m_sel_n;
    end
  end

  // Reference clock activity and slow housekeeping tick
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mref_q        <= 1'b0;
      sref_q        <= 1'b0;
      mref_cnt_q    <= 8'h00;
      main_ref_seen <= 1'b0;
      slow_tick     <= 1'b0;
    end else if (ce) begin
      mref_q <= mref_s;
      sref_q <= sref_s;
      // R4 main reference present
      if (mref_s & ~mref_q)
        mref_cnt_q <= (mref_cnt_q == `REF_SEEN_CNT) ? mref_cnt_q
                                                    : mref_cnt_q + 8'h01;
      main_ref_seen <= (mref_cnt_q == `REF_SEEN_CNT);
      // R5 slow clock edge tick
      slow_tick <= sref_s & ~sref_q;
    end
  end

  // Boot and shutdown sequencer
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q               <= `S_RESET;
      ret_q              <= `S_RESET;
      set_q              <= 32'h00000000;
      idx_q              <= 3'h0;
      start_q            <= 1'b0;
      tgt_q              <= 3'h0;
      txb_q              <= 8'h00;
      busy_d1_q          <= 1'b0;
      sys_reset_n        <= 1'b0;
      rom_addr           <= 16'h0000;
      start_addr         <= 16'h0000;
      map_enable         <= 1'b0;
      converter_reset_n  <= 1'b0;
      bbc_config_done    <= 1'b0;
      dsp_query          <= 1'b0;
      save_req           <= 1'b0;
      supply_hold_enable <= 1'b0;
      error_code         <= `ERR_NONE;
      run_idle           <= 1'b0;
    end else if (ce) begin
      start_q   <= 1'b0;
      busy_d1_q <= busy | start_q;
      // R16 low voltage forces reset
      if (!lvd_s && st_q != `S_RESET) begin
        st_q              <= `S_RESET;
        sys_reset_n       <= 1'b0;
        map_enable        <= 1'b0;
        converter_reset_n <= 1'b0;
        bbc_config_done   <= 1'b0;
        dsp_query         <= 1'b0;
        save_req          <= 1'b0;
        run_idle          <= 1'b0;
        supply_hold_enable <= 1'b0;
        // Stale fault code must not survive into the next boot
        error_code        <= `ERR_NONE;
      end else begin
        case (st_q)
          `S_RESET: begin
            set_q <= 32'h00000000;
            if (lvd_s)
              st_q <= `S_SETTLE;
          end
          // R6 settle before release
          `S_SETTLE: begin
            if (set_q >= SETTLE_CYC - 1) begin
              sys_reset_n        <= 1'b1;
              // R14 hold supply on
              supply_hold_enable <= 1'b1;
              rom_addr           <= `VEC_LO_ADDR;
              st_q               <= `S_VEC_LO;
            end else begin
              set_q <= set_q + 32'h00000001;
            end
          end
          // R7 fetch reset vector
          `S_VEC_LO: begin
            start_addr[7:0] <= rom_data;
            rom_addr        <= `VEC_HI_ADDR;
            st_q            <= `S_VEC_HI;
          end
          `S_VEC_HI: begin
            start_addr[15:8] <= rom_data;
            st_q             <= `S_MAP;
          end
          `S_MAP: begin
            map_enable <= 1'b1;
            idx_q      <= 3'h0;
            st_q       <= `S_CFG_XCVR;
          end
          // R8 transceivers configured first
          `S_CFG_XCVR: begin
            if (idx_q == NX[2:0]) begin
              st_q <= `S_REL_CONV;
            end else begin
              start_q <= 1'b1;
              tgt_q   <= idx_q + 3'h1;
              txb_q   <= {5'h00, idx_q};
              idx_q   <= idx_q + 3'h1;
              ret_q   <= `S_CFG_XCVR;
              st_q    <= `S_WAIT_XFER;
            end
          end
          // R9 release then configure
          `S_REL_CONV: begin
            converter_reset_n <= 1'b1;
            start_q           <= 1'b1;
            tgt_q             <= `TGT_BBC;
            txb_q             <= `BBC_CFG_BYTE;
            ret_q             <= `S_CFG_BBC;
            st_q              <= `S_WAIT_XFER;
          end
          `S_CFG_BBC: begin
            // R10 signal configuration done
            bbc_config_done <= 1'b1;
            st_q            <= `S_DSP_GO;
          end
          `S_DSP_GO: st_q <= `S_DIAG_RAM;
          // R11 run diagnostics
          `S_DIAG_RAM: begin
            if (!ram_s) begin
              error_code <= `ERR_RAM;
              st_q       <= `S_ERROR;
            end else begin
              st_q <= `S_DIAG_FLASH;
            end
          end
          `S_DIAG_FLASH: begin
            if (!fl_s) begin
              error_code <= `ERR_FLASH;
              st_q       <= `S_ERROR;
            end else begin
              dsp_query <= 1'b1;
              st_q      <= `S_DIAG_DSP;
            end
          end
          `S_DIAG_DSP: begin
            if (drdy_s) begin
              dsp_query <= 1'b0;
              // R12 error code or run
              if (!dst_s) begin
                error_code <= `ERR_DSP_STATUS;
                st_q       <= `S_ERROR;
              end else if (!dte_s) begin
                error_code <= `ERR_DSP_TEST;
                st_q       <= `S_ERROR;
              end else begin
                run_idle <= 1'b1;
                st_q     <= `S_RUN;
              end
            end
          end
          `S_ERROR, `S_RUN: begin
            // R13 poll supply loss
            if (loss_s) begin
              run_idle <= 1'b0;
              save_req <= 1'b1;
              st_q     <= `S_SAVE;
            end
          end
          // R15 save then release
          `S_SAVE: begin
            if (save_s) begin
              save_req           <= 1'b0;
              supply_hold_enable <= 1'b0;
              st_q               <= `S_OFF;
            end
          end
          `S_OFF: st_q <= `S_OFF;
          `S_WAIT_XFER: begin
            if (!busy && !busy_d1_q && !start_q)
              st_q <= ret_q;
          end
          default: st_q <= `S_RESET;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* dv/pwr_seq_chk.sv */
// Checker on the radio power sequencer top-level ports.
// Assumes ce held high and detect pins synced in two flops.
`timescale 1ns/10ps
`default_nettype none
module pwr_seq_chk #(
  parameter SETTLE_CYC = 20,
  parameter NT         = 4
) (
  input wire logic          clk,
  input wire logic          resetn,
  input wire logic          low_voltage_detect,
  input wire logic          sys_reset_n,
  input wire logic [15:0]   rom_addr,
  input wire logic          map_enable,
  input wire logic          converter_reset_n,
  input wire logic          bbc_config_done,
  input wire logic          save_req,
  input wire logic          supply_hold_enable,
  input wire logic [7:0]    error_code,
  input wire logic          run_idle,
  input wire logic          slow_tick,
  input wire logic          sck,
  input wire logic [NT-1:0] sel_n
);
  logic [31:0] up_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Cycles the detect pin has stood high; zero while low
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) up_q <= 32'h0;
    else if (!low_voltage_detect) up_q <= 32'h0;
    else if (up_q != 32'hFFFFFFFF) up_q <= up_q + 32'h1;
  sequence vec_fetch;
    rom_addr == 16'hFFFE ##1 rom_addr == 16'hFFFF;
  endsequence
  sequence lvd_lost;
    !low_voltage_detect [*4];
  endsequence
  AST_SETTLE: assert property (
    $rose(sys_reset_n) |-> up_q >= SETTLE_CYC) else $error("early release");
  AST_VECTOR: assert property (
    $rose(sys_reset_n) |-> vec_fetch ##[1:2] map_enable)
    else $error("vector fetch order");
  AST_LVD_RESET: assert property (
    lvd_lost |=> !sys_reset_n && !supply_hold_enable && !map_enable)
    else $error("low supply kept running");
  AST_ONE_SEL: assert property ($onehot0(~sel_n))
    else $error("two targets selected");
  AST_SCK_IDLE: assert property (&sel_n |-> !sck)
    else $error("bus clock runs idle");
  AST_XCVR_WIN: assert property (
    up_q != 32'h0 && |(~sel_n[NT-1:1]) |-> map_enable && !converter_reset_n)
    else $error("transceiver access out of order");
  AST_BBC_AFTER: assert property (
    up_q != 32'h0 && !sel_n[0] |-> converter_reset_n && !bbc_config_done)
    else $error("baseband access out of order");
  AST_DONE_AFTER: assert property (
    up_q != 32'h0 && bbc_config_done |-> converter_reset_n)
    else $error("done before release");
  AST_OK_IDLE: assert property (run_idle |-> error_code == 8'h00)
    else $error("idle with error");
  AST_LOSS_SAVE: assert property (
    $fell(run_idle) && sys_reset_n |-> save_req) else $error("no save");
  AST_HOLD: assert property (save_req |-> supply_hold_enable)
    else $error("hold dropped in save");
  AST_SAVE_FIRST: assert property (
    $fell(supply_hold_enable) && sys_reset_n |-> $past(save_req))
    else $error("hold released unsaved");
  AST_TICK: assert property (slow_tick |=> !slow_tick)
    else $error("tick too long");
endmodule
bind radio_power_sequencer pwr_seq_chk #(
  .SETTLE_CYC(SETTLE_CYC), .NT(NT)) chk (
  .clk(clk), .resetn(resetn), .low_voltage_detect(low_voltage_detect),
  .sys_reset_n(sys_reset_n), .rom_addr(rom_addr), .map_enable(map_enable),
  .converter_reset_n(converter_reset_n), .run_idle(run_idle),
  .bbc_config_done(bbc_config_done), .save_req(save_req),
  .supply_hold_enable(supply_hold_enable), .error_code(error_code),
  .slow_tick(slow_tick), .sck(sck), .sel_n(sel_n));
`default_nettype wire

/* dv/cfg_slaves.sv */
// Partner: configuration bus targets and the supply detector.
// Assumes mode 0 framing, MSB first, one byte per select.
`timescale 1ns/10ps
`default_nettype none
module cfg_slaves #(
  parameter NT = 4
) (
  input  wire logic          sck,
  input  wire logic          mosi,
  input  wire logic [NT-1:0] sel_n,
  input  wire logic [15:0]   supply_mv,
  output wire logic          miso,
  output wire logic          lvd
);
  localparam logic [7:0] REPLY = 8'hC3;
  logic [7:0] sh [NT];
  logic [7:0] got [NT];
  int         nb [NT];
  int         total = 0;
  int         rb = 0;
  logic       idle_q = 1'b0;
  assign lvd = supply_mv > 16'h1068;
  // selected target shifts in on rising clock
  always @(posedge sck)
    for (int i = 0; i < NT; i++)
      if (!sel_n[i]) begin
        sh[i] = {sh[i][6:0], mosi};
        nb[i] = nb[i] + 1;
        if (nb[i] == 8) begin
          got[i] = sh[i];
          nb[i] = 0;
          total = total + 1;
        end
      end
  // only baseband answers; released line shows inverse of last bit
  always @(negedge sel_n[0]) rb = 0;
  always @(negedge sck) if (!sel_n[0] && rb < 7) rb = rb + 1;
  always @(posedge sel_n[0]) idle_q = ~REPLY[3'(7 - rb)];
  assign miso = sel_n[0] ? idle_q : REPLY[3'(7 - rb)];
endmodule
`default_nettype wire

/* dv/test_radio_power_sequencer.sv */
// Testbench: boot with each diagnostic fault, shutdown, supply loss.
// Assumes the cfg_slaves partner and a combinational vector ROM.
`timescale 1ns/10ps
`default_nettype none
module test_radio_power_sequencer;
  localparam int SET = 20;
  logic        clk, resetn, ce, mref, sref, lvd, loss, miso, sck, mosi;
  logic        ram_ok, flash_ok, st_ok, tst_ok, dsp_ready, save_done;
  logic [15:0] supply_mv, rom_addr, start_addr;
  logic [7:0]  rom_data, error_code;
  logic        sys_reset_n, map_enable, converter_reset_n, bbc_config_done;
  logic        dsp_query, save_req, hold, run_idle, ref_seen, slow_tick;
  logic [3:0]  sel_n;
  int          errors, checks_done, n, t0;
  radio_power_sequencer #(.SETTLE_CYC(SET), .NT(4), .NX(3)) uut (
    .clk(clk), .resetn(resetn), .ce(ce), .main_ref_clock_in(mref),
    .slow_ref_clock_in(sref), .low_voltage_detect(lvd),
    .supply_loss_sense(loss), .ram_ok(ram_ok), .flash_ok(flash_ok),
    .dsp_status_ok(st_ok), .dsp_test_ok(tst_ok), .dsp_ready(dsp_ready),
    .save_done(save_done), .rom_data(rom_data), .miso(miso),
    .sys_reset_n(sys_reset_n), .rom_addr(rom_addr),
    .start_addr(start_addr), .map_enable(map_enable),
    .converter_reset_n(converter_reset_n), .dsp_query(dsp_query),
    .bbc_config_done(bbc_config_done), .save_req(save_req),
    .supply_hold_enable(hold), .error_code(error_code),
    .run_idle(run_idle), .main_ref_seen(ref_seen),
    .slow_tick(slow_tick), .sck(sck), .mosi(mosi), .sel_n(sel_n));
  cfg_slaves #(.NT(4)) sl (.sck(sck), .mosi(mosi), .sel_n(sel_n),
    .supply_mv(supply_mv), .miso(miso), .lvd(lvd));
  // Vector ROM: start address 1234
  assign rom_data = rom_addr == 16'hFFFE ? 8'h34 :
                    rom_addr == 16'hFFFF ? 8'h12 : 8'h00;
  // System, main reference and slow clocks
  always #50 clk = ~clk;
  always #29.762 mref = ~mref;
  always #15625 sref = ~sref;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return sys_reset_n;
      1: return map_enable;
      2: return converter_reset_n;
      3: return bbc_config_done;
      4: return dsp_query;
      5: return run_idle | (|error_code);
      6: return save_req;
      7: return !hold;
      default: return !sys_reset_n;
    endcase
  endfunction
  // Bounded wait on falling edges; n holds the cycles taken
  task automatic wait_sig(input int k);
    n = 0;
    while (sig(k) !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 3000) begin
        errors++;
        stop_test();
      end
    end
  endtask
  task automatic t_reset;
    @(negedge clk);
    check({sys_reset_n, hold, map_enable}, 0);
    check(sel_n, 4'hF);
  endtask
  // Power up with diagnostic f failing, 0 for none
  task automatic t_boot(input int f);
    @(posedge clk);
    {tst_ok, st_ok, flash_ok, ram_ok} <= 4'(~(5'h1 << f >> 1));
    dsp_ready <= 0;
    supply_mv <= 16'h1388;
    t0 = sl.total;
    @(negedge clk);
    wait_sig(0);
    check(n >= SET && n <= SET + 6, 1);
    wait_sig(1);
    check(start_addr, 16'h1234);
    wait_sig(2);
    check(sl.total - t0, 3);
    wait_sig(3);
    check(sl.total - t0, 4);
    for (int j = 0; j < 4; j++) check(sl.got[j], j ? j - 1 : 8'hA5);
    if (f == 0 || f > 2) begin
      wait_sig(4);
      repeat (4) @(negedge clk);
      check({run_idle, error_code, dsp_query}, 1);
      @(posedge clk);
      dsp_ready <= 1;
    end
    wait_sig(5);
    check(error_code, f);
    check(run_idle, f == 0);
    check(dsp_query, 0);
  endtask
  task automatic t_drop;
    @(posedge clk);
    supply_mv <= 16'h0;
    loss <= 0;
    save_done <= 0;
    @(negedge clk);
    wait_sig(8);
    check(n <= 5, 1);
    @(negedge clk);
    check({sel_n, hold, converter_reset_n, map_enable}, 7'h78);
  endtask
  task automatic t_shutdown;
    @(posedge clk);
    loss <= 1;
    @(negedge clk);
    wait_sig(6);
    check(run_idle, 0);
    repeat (20) @(negedge clk);
    check({save_req, hold}, 2'h3);
    @(posedge clk);
    save_done <= 1;
    @(negedge clk);
    wait_sig(7);
    check(save_req, 0);
  endtask
  // Slow ticks over ten slow periods
  task automatic t_clocks;
    check(ref_seen, 1);
    @(posedge sref);
    n = 0;
    repeat (3125) begin
      @(negedge clk);
      n += slow_tick;
    end
    check(n, 10);
  endtask
  initial begin
    clk = 0;
    mref = 0;
    sref = 0;
    resetn = 0;
    ce = 1;
    loss = 0;
    {ram_ok, flash_ok, st_ok, tst_ok} = 4'hF;
    dsp_ready = 0;
    save_done = 0;
    supply_mv = 16'h0;
    errors = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    resetn <= 1;
    t_reset();
    for (int f = 4; f >= 0; f--) begin
      t_boot(f);
      if (f) t_drop();
    end
    t_clocks();
    t_shutdown();
    t_drop();
    stop_test();
  end
endmodule
`default_nettype wire
